// file: pdrs_top.sv
`timescale 1ns/10ps
module pdrs_top (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              clk_en,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire pdrs_pkg::pdrs_cfg_s cfg,
  input  wire pdrs_pkg::pdrs_tim_s tim,
  input  wire logic              shutdown_cause,
  input  wire logic              cause_is_comparator,
  input  wire logic              comparator_sync_enable,
  input  wire logic              restart_force_off,
  input  wire logic              port_a,
  input  wire logic              port_b,
  output pdrs_pkg::pdrs_pin_s    pins,
  output logic                   shutdown_active
);
  import pdrs_pkg::*;

  // ==========================================================
  // state
  logic [7:0]  addr_q, addr_d;
  logic        wr_q, wr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0]  dly_q, dly_d;
  logic [7:0]  steer_q, steer_d;
  logic [7:0]  act_q, act_d;
  logic [1:0]  div_q, div_d;
  logic        sd_q, sd_d;
  logic        cause_q, cause_d;
  logic        raw_q, raw_d;
  logic        wait_q, wait_d;
  logic [6:0]  cnt_q, cnt_d;
  logic        out_q, out_d;
  logic        take, rd_now, instr_tick;
  logic        wr_dly, wr_steer, wr_stat;

  // ==========================================================
  // bus slave
  // size not decoded: only whole-word transfers exist
  assign take      = hsel && hready && htrans[1];
  assign rd_now    = take && !hwrite;
  assign wr_dly    = wr_q && addr_q == PDRS_ADDR_DLY;
  assign wr_steer  = wr_q && addr_q == PDRS_ADDR_STEER;
  assign wr_stat   = wr_q && addr_q == PDRS_ADDR_STAT;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // built from next values, so a read right behind a write
  // already returns what that write stores
  always_comb
  begin
    addr_d  = take ? haddr[7:0] : addr_q;
    wr_d    = take && hwrite;
    rdata_d = 32'h0;
    if (rd_now)
    begin
      unique case (haddr[7:0])
        PDRS_ADDR_DLY:   rdata_d = {24'h0, dly_d};
        PDRS_ADDR_STEER: rdata_d = {24'h0, steer_d};
        PDRS_ADDR_STAT:  rdata_d = {31'h0, sd_d};
        default:         rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q  <= 8'h00;
      wr_q    <= 1'b0;
      rdata_q <= 32'h0;
    end
    else if (clk_en)
    begin
      addr_q  <= addr_d;
      wr_q    <= wr_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // control registers
  always_comb
  begin
    dly_d   = dly_q;
    steer_d = steer_q;
    if (wr_dly)
      dly_d = hwdata[7:0];
    if (restart_force_off)
      dly_d[PDRS_RSEN_BIT] = 1'b0;
    if (wr_steer)
      steer_d = hwdata[7:0] & PDRS_STEER_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dly_q   <= PDRS_RST_DLY;
      steer_q <= PDRS_RST_STEER;
    end
    else if (clk_en)
    begin
      dly_q   <= dly_d;
      steer_q <= steer_d;
    end
  end

  // ==========================================================
  // auto-shutdown and restart
  always_comb
  begin
    cause_d = cause_q;
    sd_d    = sd_q;
    if (!(cause_is_comparator && comparator_sync_enable) || tim.timer1_tick)
      cause_d = shutdown_cause;
    if (wr_stat && !hwdata[0])
      sd_d = 1'b0;
    if (dly_q[PDRS_RSEN_BIT] && !cause_d && sd_q)
      sd_d = 1'b0;
    // set wins, so a live cause is never lost to a clear
    if (cause_d)
      sd_d = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cause_q <= 1'b0;
      sd_q    <= 1'b0;
    end
    else if (clk_en)
    begin
      cause_q <= cause_d;
      sd_q    <= sd_d;
    end
  end

  // ==========================================================
  // instruction-cycle divider and steering update
  // free-running, so an unsynced change lands within four clocks
  assign instr_tick = div_q == PDRS_DIV_LAST;

  always_comb
  begin
    div_d = div_q + 2'h1;
    act_d = act_q;
    if (steer_q[PDRS_SYNC_BIT] ? tim.period_start : instr_tick)
      act_d = steer_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_q <= 2'h0;
      act_q <= PDRS_RST_STEER;
    end
    else if (clk_en)
    begin
      div_q <= div_d;
      act_q <= act_d;
    end
  end

  // ==========================================================
  // active-edge delay
  always_comb
  begin
    raw_d  = tim.pwm_raw;
    cnt_d  = cnt_q;
    wait_d = wait_q;
    out_d  = out_q;
    if (tim.pwm_raw && !raw_q)
    begin
      if (dly_q[6:0] == 7'h0)
        out_d = 1'b1;
      else
      begin
        cnt_d  = dly_q[6:0];
        wait_d = 1'b1;
      end
    end
    else if (wait_q && instr_tick)
    begin
      cnt_d = cnt_q - 7'h1;
      if (cnt_q == 7'h1)
      begin
        wait_d = 1'b0;
        out_d  = tim.pwm_raw;
      end
    end
    if (!tim.pwm_raw)
    begin
      out_d  = 1'b0;
      wait_d = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      raw_q  <= 1'b0;
      cnt_q  <= 7'h00;
      wait_q <= 1'b0;
      out_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      raw_q  <= raw_d;
      cnt_q  <= cnt_d;
      wait_q <= wait_d;
      out_q  <= out_d;
    end
  end

  // ==========================================================
  // pin steering
  logic steer_ok, wave;
  assign steer_ok = cfg.unit_mode_upper == PDRS_MODE_PWM &&
                    cfg.output_config_bits == PDRS_CFG_SINGLE;
  assign wave = out_q && !sd_q;
  assign shutdown_active = sd_q;
  always_comb
  begin
    pins.steer_a = steer_ok && act_q[PDRS_STA_BIT];
    pins.steer_b = steer_ok && act_q[PDRS_STB_BIT];
    pins.pin_a = pins.steer_a ? wave ^ cfg.output_polarity_bits[1] : port_a;
    pins.pin_b = pins.steer_b ? wave ^ cfg.output_polarity_bits[0] : port_b;
  end
endmodule : pdrs_top

// file: pdrs_pkg.sv
// How it works
// - each active-going edge is held off by the seven-bit delay count in instruction cycles.
// - sync bit set updates steering at period start, else at next instruction cycle.
// - steer enable b puts the polarity-controlled waveform on pin b, else port pin.
// - steer enable a puts the waveform on pin a, else port pin; resets to one.
// - steering applies only in pwm mode with single-output configuration.
// - reserved steering bits and upper three bits read as zero; software writes zero.
// - comparator-caused shutdown waits for the timer clock when sync is enabled.
// - restart enable forced to zero under two-speed crystal start-up or fail-safe.
package pdrs_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] PDRS_ADDR_DLY   = 8'h00;
  localparam logic [7:0] PDRS_ADDR_STEER = 8'h04;
  localparam logic [7:0] PDRS_ADDR_STAT  = 8'h08;
  localparam logic [7:0] PDRS_RST_DLY    = 8'h00;
  localparam logic [7:0] PDRS_RST_STEER  = 8'h01;
  localparam int         PDRS_RSEN_BIT   = 7;
  localparam int         PDRS_SYNC_BIT   = 4;
  localparam int         PDRS_STB_BIT    = 1;
  localparam int         PDRS_STA_BIT    = 0;
  localparam logic [7:0] PDRS_STEER_MASK = 8'h13;
  localparam logic [1:0] PDRS_MODE_PWM   = 2'h3;
  localparam logic [1:0] PDRS_CFG_SINGLE = 2'h0;
  localparam int         PDRS_INSTR_DIV  = 4;
  localparam logic [1:0] PDRS_DIV_LAST   = 2'(PDRS_INSTR_DIV - 1);

  typedef struct packed {
    logic [1:0] unit_mode_upper;
    logic [1:0] output_polarity_bits;
    logic [1:0] output_config_bits;
  } pdrs_cfg_s;

  typedef struct packed {
    logic pwm_raw;
    logic period_start;
    logic timer1_tick;
  } pdrs_tim_s;

  typedef struct packed {
    logic pin_a;
    logic pin_b;
    logic steer_a;
    logic steer_b;
  } pdrs_pin_s;
endpackage : pdrs_pkg

// file: pdrs_top_properties.sv
`timescale 1ns/10ps
module pdrs_chk (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                clk_en,
  input wire pdrs_pkg::pdrs_cfg_s cfg,
  input wire pdrs_pkg::pdrs_tim_s tim,
  input wire logic                shutdown_cause,
  input wire logic                cause_is_comparator,
  input wire logic                comparator_sync_enable,
  input wire logic                port_a,
  input wire logic                port_b,
  input wire pdrs_pkg::pdrs_pin_s pins,
  input wire logic                shutdown_active
);
  import pdrs_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // pins and shutdown
  property p_pa;
    !pins.steer_a |-> pins.pin_a == port_a;
  endproperty
  a_pa: assert property (p_pa) else $error("pin a");
  property p_pb;
    !pins.steer_b |-> pins.pin_b == port_b;
  endproperty
  a_pb: assert property (p_pb) else $error("pin b");
  property p_ma;
    pins.steer_a |-> cfg.unit_mode_upper == PDRS_MODE_PWM
      && cfg.output_config_bits == PDRS_CFG_SINGLE;
  endproperty
  a_ma: assert property (p_ma) else $error("mode a");
  property p_mb;
    pins.steer_b |-> cfg.unit_mode_upper == PDRS_MODE_PWM
      && cfg.output_config_bits == PDRS_CFG_SINGLE;
  endproperty
  a_mb: assert property (p_mb) else $error("mode b");
  property p_sd;
    $rose(shutdown_active) |-> $past(shutdown_cause);
  endproperty
  a_sd: assert property (p_sd) else $error("shutdown");
  property p_cs;
    $rose(shutdown_active) && $past(cause_is_comparator)
      && $past(comparator_sync_enable) |-> $past(tim.timer1_tick);
  endproperty
  a_cs: assert property (p_cs) else $error("sync");
  // an edge seen before the raw waveform would mean no hold-off
  property p_rs;
    pins.steer_a && $past(pins.steer_a) && !$past(shutdown_active)
      && !cfg.output_polarity_bits[1] && $rose(pins.pin_a)
      |-> $past(tim.pwm_raw);
  endproperty
  a_rs: assert property (p_rs) else $error("early");
  property p_fl;
    clk_en && pins.steer_a && !cfg.output_polarity_bits[1]
      && $fell(tim.pwm_raw) |=> !pins.steer_a || !pins.pin_a;
  endproperty
  a_fl: assert property (p_fl) else $error("fall");
endmodule : pdrs_chk
bind pdrs_top pdrs_chk u_chk (.*);

// file: pdrs_drv_model.sv
`timescale 1ns/10ps
module pdrs_drv_model (
  input  wire logic hclk,
  input  wire logic pin_a,
  input  wire logic pin_b,
  output logic      stage_a,
  output logic      stage_b
);
  // power stage follows its gate one cycle late
  always_ff @(posedge hclk)
  begin
    stage_a <= pin_a;
    stage_b <= pin_b;
  end
endmodule : pdrs_drv_model

// file: pdrs_top_tb.sv
`timescale 1ns/10ps
module pdrs_top_tb;
  import pdrs_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        cause = 1'b0, comp = 1'b0, csync = 1'b0, rfo = 1'b0;
  logic        pa = 1'b1, pb = 1'b0;
  logic        hreadyout, hresp, shut;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_q, r;
  pdrs_cfg_s   cfg = '{2'h3, 2'h0, 2'h0};
  pdrs_tim_s   tim = '0;
  pdrs_pin_s   pins;
  int          fail_count, comparisons, cyc, n;
  pdrs_top u_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cfg(cfg), .tim(tim),
    .shutdown_cause(cause), .cause_is_comparator(comp),
    .comparator_sync_enable(csync), .restart_force_off(rfo),
    .port_a(pa), .port_b(pb), .pins(pins), .shutdown_active(shut));
  pdrs_drv_model u_drv (.hclk(hclk), .pin_a(pins.pin_a),
    .pin_b(pins.pin_b), .stage_a(), .stage_b());
  initial forever #12.5 hclk = ~hclk;
  // read data captured at the edge, not after it updates
  always @(posedge hclk)
  begin
    rd_q <= hrdata;
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  // ==========================================================
  // bus and compare
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    @(negedge hclk) r = rd_q;
  endtask : bus
  // ==========================================================
  // scenarios
  task t_regs;
    bus(1'b0, PDRS_ADDR_DLY, '0);
    chk(r, {24'h0, PDRS_RST_DLY});
    bus(1'b0, PDRS_ADDR_STEER, '0);
    chk(r, {24'h0, PDRS_RST_STEER});
    bus(1'b1, PDRS_ADDR_STEER, 32'hF3);
    bus(1'b0, PDRS_ADDR_STEER, '0);
    chk(r, 32'h13);
    bus(1'b1, PDRS_ADDR_DLY, 32'hFF);
    bus(1'b0, PDRS_ADDR_DLY, '0);
    chk(r, 32'hFF);
    bus(1'b1, 8'h0C, 32'hFF);
    bus(1'b0, 8'h0C, '0);
    chk(r, 32'h00);
  endtask : t_regs
  task t_dly(input logic [6:0] c, input int lo, input int hi);
    bus(1'b1, PDRS_ADDR_DLY, {25'h0, c});
    @(posedge hclk) tim.pwm_raw <= 1'b1;
    n = 0;
    while (pins.pin_a !== 1'b1 && n < 600)
    begin
      @(negedge hclk);
      n++;
    end
    chk(n >= lo && n <= hi, 1);
    @(posedge hclk) tim.pwm_raw <= 1'b0;
    repeat (2) @(negedge hclk);
    chk(pins.pin_a, 1'b0);
  endtask : t_dly
  task t_steer;
    bus(1'b1, PDRS_ADDR_STEER, 32'h12);
    repeat (6) @(negedge hclk);
    chk({pins.steer_a, pins.steer_b}, 2'b10);
    chk(pins.pin_b, 1'b0);
    @(posedge hclk) tim.period_start <= 1'b1;
    @(posedge hclk) tim.period_start <= 1'b0;
    @(negedge hclk) chk({pins.steer_a, pins.steer_b, pins.pin_a}, 3'b011);
    @(posedge hclk) pa <= 1'b0;
    @(negedge hclk) chk(pins.pin_a, 1'b0);
    bus(1'b1, PDRS_ADDR_STEER, 32'h03);
    repeat (5) @(negedge hclk);
    chk({pins.steer_a, pins.steer_b}, 2'b11);
    @(posedge hclk) cfg.output_polarity_bits <= 2'b10;
    @(negedge hclk) chk({pins.pin_a, pins.pin_b}, 2'b10);
    @(posedge hclk) cfg.output_polarity_bits <= 2'b01;
    @(negedge hclk) chk({pins.pin_a, pins.pin_b}, 2'b01);
    @(posedge hclk) cfg.output_polarity_bits <= 2'b00;
    @(posedge hclk) cfg.unit_mode_upper <= 2'h2;
    repeat (5) @(negedge hclk);
    chk({pins.steer_a, pins.steer_b}, 2'b00);
    @(posedge hclk) cfg.unit_mode_upper <= PDRS_MODE_PWM;
  endtask : t_steer
  task sd(input logic [31:0] d, input logic e);
    bus(1'b1, PDRS_ADDR_DLY, d);
    @(posedge hclk) cause <= 1'b1;
    @(posedge hclk) cause <= 1'b0;
    @(negedge hclk) chk(shut, 1'b1);
    repeat (4) @(negedge hclk);
    chk(shut, e);
    bus(1'b1, PDRS_ADDR_STAT, '0);
    chk(shut, 1'b0);
  endtask : sd
  task t_shut;
    sd(32'h80, 1'b0);
    sd(32'h00, 1'b1);
    @(posedge hclk) rfo <= 1'b1;
    sd(32'h80, 1'b1);
    @(posedge hclk) rfo <= 1'b0;
  endtask : t_shut
  task t_cmp;
    @(posedge hclk) cause <= 1'b1;
    comp <= 1'b1;
    csync <= 1'b1;
    repeat (6) @(negedge hclk);
    chk(shut, 1'b0);
    @(posedge hclk) tim.timer1_tick <= 1'b1;
    @(posedge hclk) tim.timer1_tick <= 1'b0;
    cause <= 1'b0;
    @(negedge hclk) chk(shut, 1'b1);
  endtask : t_cmp
  task wrap_up;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_dly(7'h00, 2, 2);
    t_dly(7'h03, 10, 16);
    t_dly(7'h7F, 506, 512);
    t_steer();
    t_shut();
    t_cmp();
    wrap_up();
  end
endmodule : pdrs_top_tb
